// *** hw/cache_opt_defines.svh ***
// Purpose: offsets, field positions, reset values and counts of the sideband block
// Assumes: byte addresses on the register bus
// Notes: definitions only
`ifndef CACHE_OPT_DEFINES_SVH
`define CACHE_OPT_DEFINES_SVH
`define speculative_read_build_option 1'b1
`define OFS_AUX_CTRL 4'h0
`define OFS_PF_CTRL 4'h4
`define OFS_STATUS 4'h8
`define AUX_FLZ_BIT 0
`define AUX_DEVLIM_BIT 11
`define AUX_PF_D_BIT 28
`define AUX_PF_I_BIT 29
`define AUX_EARLY_BIT 30
`define PF_OFS_MSB 4
`define AUX_RESET 32'h0000_0000
`define PF_RESET 32'h0000_0000
`define AUX_WMASK 32'h7000_0801
`define PF_WMASK 32'h3000_001f
`define AW_EARLY_BIT 11
`define AW_ZERO_BIT 10
`define AR_SPEC_BIT 9
`define AR_HINT_BIT 8
`define LINE_BYTES 32
`define PAGE_LSB 12
`define SB_SLOTS 3
`define SPEC_TIMEOUT 64
`endif

// *** hw/cache_opt_pkg.sv ***
// Purpose: shared types of the sideband block
// Assumes: nothing
// Notes: states and lookup kinds
package cache_opt_pkg;
	typedef enum logic [1:0] {LK_NORMAL, LK_HINT, LK_SPEC, LK_CONFIRM} lookup_kind_t;
	typedef enum logic [1:0] {WR_IDLE, WR_STORE, WR_DATA, WR_RESP} wr_state_t;
	typedef enum logic [1:0] {PF_IDLE, PF_LOOKUP, PF_RESULT, PF_FETCH} pf_state_t;
endpackage

// *** hw/opt_links_if.sv ***
// Purpose: links between the slave port and its prefetch and speculation helpers
// Assumes: one clock
// Notes: hit and full are combinational answers
`timescale 1ns/1ps
interface pf_link_if #(parameter int AW = 32);
	logic trig;
	logic [AW-1:0] trig_addr;
	logic [4:0] offset;
	logic busy;
	modport src (output trig, trig_addr, offset, input busy);
	modport eng (input trig, trig_addr, offset, output busy);
endinterface

interface spec_link_if #(parameter int IW = 4, parameter int AW = 32);
	logic open_req;
	logic conf_req;
	logic [AW-1:0] addr;
	logic [IW-1:0] id;
	logic hit;
	logic full;
	modport src (output open_req, conf_req, addr, id, input hit, full);
	modport trk (input open_req, conf_req, addr, id, output hit, full);
endinterface

// *** hw/prefetch_engine.sv ***
// Purpose: launches one prefetch lookup and, on a miss, one L3 line fetch
// Assumes: lookup result arrives as a one-cycle pulse
// Notes: triggers arriving while busy are dropped, prefetch is only a hint
`timescale 1ns/1ps
`include "cache_opt_defines.svh"
module prefetch_engine import cache_opt_pkg::*; #(
	parameter int AW = 32 // address width
) (
	input wire logic clk_i, // core clock
	input wire logic reset_n_i, // synchronous reset, active low
	pf_link_if.eng link, // trigger from the slave port
	output logic lk_valid_o, // prefetch lookup request
	input wire logic lk_ready_i, // lookup taken
	output logic [AW-1:0] addr_o, // target line address
	input wire logic res_valid_i, // lookup result pulse
	input wire logic res_miss_i, // result was a miss
	output logic l3_valid_o, // line fetch request to L3
	input wire logic l3_ready_i // fetch taken
);
	localparam int LSB = $clog2(`LINE_BYTES);
	localparam int LW = AW - LSB;
	pf_state_t state, next_state;
	wire [LW-1:0] next_line = link.trig_addr[AW-1:LSB] + LW'(link.offset) + LW'(1); // see R18 see R22
	wire same_page = next_line[LW-1:`PAGE_LSB-LSB] == link.trig_addr[AW-1:`PAGE_LSB];
	wire launch = link.trig && state == PF_IDLE && same_page; // see R20
	assign link.busy = state != PF_IDLE;

	always_comb begin
		next_state = state;
		case (state)
			PF_IDLE: if (launch) next_state = PF_LOOKUP; // see R17
			PF_LOOKUP: if (lk_ready_i) next_state = PF_RESULT;
			PF_RESULT: if (res_valid_i) next_state = res_miss_i ? PF_FETCH : PF_IDLE; // see R19
			PF_FETCH: if (l3_ready_i) next_state = PF_IDLE;
			default: next_state = PF_IDLE;
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (!reset_n_i) begin
			state <= PF_IDLE;
			lk_valid_o <= 1'b0;
			l3_valid_o <= 1'b0;
			addr_o <= '0;
		end else begin
			state <= next_state;
			lk_valid_o <= next_state == PF_LOOKUP;
			l3_valid_o <= next_state == PF_FETCH;
			if (launch)
				addr_o <= {next_line, {LSB{1'b0}}};
		end
	end

	default clocking @(posedge clk_i); endclocking
	default disable iff (!reset_n_i);
	a_pf_target_line: assert property (launch |=> lk_valid_o && addr_o == {$past(next_line), {LSB{1'b0}}}) // see R18
		else $error("prefetch target line wrong");
	a_pf_page_block: assert property (link.trig && state == PF_IDLE && !same_page |=> !lk_valid_o) // see R20
		else $error("prefetch crossed a 4KB page");
	a_pf_miss_fetch: assert property (state == PF_RESULT && res_valid_i && res_miss_i |=> l3_valid_o) // see R19
		else $error("prefetch miss not fetched");
endmodule

// *** hw/spec_read_tracker.sv ***
// Purpose: holds pending speculative reads until confirmed or terminated
// Assumes: slave port never opens an entry while full
// Notes: one end per cycle, later ends wait a cycle
`timescale 1ns/1ps
`include "cache_opt_defines.svh"
module spec_read_tracker import cache_opt_pkg::*; #(
	parameter int DEPTH = 2, // pending speculative reads
	parameter int TIMEOUT = `SPEC_TIMEOUT, // cycles before termination
	parameter int IW = 4, // axi id width
	parameter int AW = 32 // address width
) (
	input wire logic clk_i, // core clock
	input wire logic reset_n_i, // synchronous reset, active low
	input wire logic conflict_i, // resource conflict, ends lowest valid slot
	spec_link_if.trk link, // from the slave port
	output logic end_strobe_o, // speculative read ended
	output logic [IW-1:0] end_id_o // id of the ended read
);
	localparam int LSB = $clog2(`LINE_BYTES);
	localparam int CW = $clog2(TIMEOUT + 1);
	logic [DEPTH-1:0] valid;
	logic [IW-1:0] ids [DEPTH];
	logic [AW-LSB-1:0] lines [DEPTH];
	logic [CW-1:0] age [DEPTH];
	logic [DEPTH-1:0] match;
	logic [DEPTH-1:0] expired;

	function automatic int first_set(input logic [DEPTH-1:0] v);
		first_set = 0;
		for (int i = DEPTH - 1; i >= 0; i--)
			if (v[i])
				first_set = i;
	endfunction

	for (genvar g = 0; g < DEPTH; g++) begin : g_ent
		assign match[g] = valid[g] && lines[g] == link.addr[AW-1:LSB];
		assign expired[g] = valid[g] && age[g] == CW'(TIMEOUT);
		always_ff @(posedge clk_i) begin
			if (!reset_n_i || !valid[g])
				age[g] <= '0;
			else if (!expired[g])
				age[g] <= age[g] + CW'(1);
		end
	end

	wire conf_end = link.conf_req && |match; // see R12
	wire any_end = conf_end || |expired || (conflict_i && |valid); // see R13
	wire [DEPTH-1:0] end_vec = conf_end ? match : (|expired ? expired : valid);
	int kill;
	int free_slot;
	assign kill = first_set(end_vec);
	assign free_slot = first_set(~valid);
	assign link.hit = |match;
	assign link.full = &valid;

	always_ff @(posedge clk_i) begin
		if (!reset_n_i) begin
			valid <= '0;
			end_strobe_o <= 1'b0;
			end_id_o <= '0;
		end else begin
			end_strobe_o <= any_end; // see R14
			if (any_end) begin
				end_id_o <= ids[kill];
				valid[kill] <= 1'b0;
			end
			if (link.open_req && !link.full) begin // see R11
				valid[free_slot] <= 1'b1;
				ids[free_slot] <= link.id;
				lines[free_slot] <= link.addr[AW-1:LSB];
			end
		end
	end

	default clocking @(posedge clk_i); endclocking
	default disable iff (!reset_n_i);
	sequence s_confirm;
		link.conf_req && match[0];
	endsequence
	a_conf_end_id: assert property (s_confirm |=> end_strobe_o && end_id_o == $past(ids[0])) // see R14
		else $error("confirmation did not end speculative read");
	a_spec_timeout: assert property (|expired |=> end_strobe_o) // see R13
		else $error("expired speculative read not terminated");
endmodule

// *** hw/cache_sideband_opt_prefetch.sv ***
// Purpose: slave-port sideband options, device write cap and prefetch launch
// Assumes: store buffer, lookup pipe and line read buffers sit outside
// Notes: registers on Avalon-MM, each access answers on its second cycle
`timescale 1ns/1ps
`include "cache_opt_defines.svh"

// Summary of operation
// R1 - early write response once store buffer takes address
// R2 - early response off until aux bit 30
// R3 - early response only for writes tagged user bit 11
// R4 - read user bit 8 is hint, no data
// R5 - other masters keep read user bit 8 low
// R6 - write user bit 10 zeroes whole line
// R7 - zero write ignores size, length, data, strobes
// R8 - line zeroing off until aux bit 0
// R9 - software enables zeroing here before processor
// R10 - no strongly ordered writes with user bit 10
// R11 - read user bit 9 is speculative, no data
// R12 - matching confirmation read merges, returns prepared data
// R13 - unconfirmed speculative read ends on timeout, conflict
// R14 - every speculative end pulses strobe with id
// R15 - speculative logic built only under build option
// R16 - aux bit 11 keeps one slot for normal
// R17 - prefetch enables make cacheable reads trigger lookup
// R18 - target line is line plus one plus offset
// R19 - prefetch miss fetches from L3 and allocates
// R20 - no prefetch across a 4KB page
// R21 - store buffer has three 256-bit slots
// R22 - cache line is 32 bytes
// R23 - sideband sampled at address handshake, kept attached
module cache_sideband_opt_prefetch import cache_opt_pkg::*; #(
	parameter int AW = 32, // address width
	parameter int IW = 4, // axi id width
	parameter int UW = 12, // user sideband width
	parameter int LENW = 8, // burst length width
	parameter int SPEC_DEPTH = 2, // pending speculative reads
	parameter int SPEC_TIMEOUT = `SPEC_TIMEOUT, // cycles before termination
	parameter bit SPEC_READ_OPTION = `speculative_read_build_option // build speculative logic
) (
	input wire logic clk_i, // core clock
	input wire logic reset_n_i, // synchronous reset, active low
	input wire logic [3:0] av_address_i, // register byte address
	input wire logic av_read_i, // register read
	input wire logic av_write_i, // register write
	input wire logic [3:0] av_byteenable_i, // write byte lanes
	input wire logic [31:0] av_writedata_i, // write data
	output logic [31:0] av_readdata_o, // read data
	output logic av_waitrequest_o, // bus stall
	input wire logic aw_valid_i, // write address valid
	output logic aw_ready_o, // write address ready
	input wire logic [AW-1:0] aw_addr_i, // write address
	input wire logic [IW-1:0] aw_id_i, // write id
	input wire logic [LENW-1:0] aw_len_i, // write burst length
	input wire logic aw_device_i, // device memory write
	input wire logic [UW-1:0] write_addr_user_sideband, // write user bits
	input wire logic w_last_done_i, // store buffer took last data beat
	output logic b_valid_o, // write response valid
	input wire logic b_ready_i, // write response ready
	output logic [IW-1:0] b_id_o, // write response id
	output logic sb_valid_o, // address to store buffer
	input wire logic sb_ready_i, // store buffer took address
	output logic [AW-1:0] sb_addr_o, // store buffer address
	output logic [LENW-1:0] sb_len_o, // store buffer burst length
	output logic sb_zero_line_o, // zero the whole line
	output logic sb_device_o, // device write
	input wire logic sb_dev_drained_i, // a device slot drained
	input wire logic ar_valid_i, // read address valid
	output logic ar_ready_o, // read address ready
	input wire logic [AW-1:0] ar_addr_i, // read address
	input wire logic [IW-1:0] ar_id_i, // read id
	input wire logic ar_cacheable_i, // cacheable read
	input wire logic [UW-1:0] read_addr_user_sideband, // read user bits
	output logic lk_valid_o, // read lookup request
	input wire logic lk_ready_i, // lookup taken
	output logic [AW-1:0] lk_addr_o, // lookup address
	output logic [IW-1:0] lk_id_o, // lookup id
	output lookup_kind_t lk_kind_o, // normal, hint, speculative, confirm
	output logic pf_lk_valid_o, // prefetch lookup request
	input wire logic pf_lk_ready_i, // prefetch lookup taken
	output logic [AW-1:0] pf_addr_o, // prefetch line address
	input wire logic pf_res_valid_i, // prefetch lookup result
	input wire logic pf_res_miss_i, // prefetch lookup missed
	output logic pf_l3_valid_o, // prefetch fetch from L3
	input wire logic pf_l3_ready_i, // L3 fetch taken
	input wire logic spec_conflict_i, // resource conflict
	output logic spec_read_end_strobe, // speculative read ended
	output logic [IW-1:0] spec_read_end_id // id of ended read
);
	localparam int LSB = $clog2(`LINE_BYTES);
	localparam int CNTW = $clog2(`SB_SLOTS + 1);

	logic [31:0] aux_ctrl;
	logic [31:0] pf_ctrl;
	wr_state_t wr_state, next_wr_state;
	logic w_early;
	logic w_data_done;
	logic w_sent;
	logic [CNTW-1:0] dev_cnt;

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd, input logic [31:0] m);
		merge = (old & ~m) | (wd & m);
	endfunction

	spec_link_if #(.IW(IW), .AW(AW)) spec_link ();
	pf_link_if #(.AW(AW)) pf_link ();

	// register bus
	wire av_req = av_read_i || av_write_i;
	wire av_wr = av_write_i && !av_waitrequest_o;
	wire [31:0] be_bits = {{8{av_byteenable_i[3]}}, {8{av_byteenable_i[2]}},
		{8{av_byteenable_i[1]}}, {8{av_byteenable_i[0]}}};
	wire [31:0] status = 32'({spec_link.full, pf_link.busy, lk_valid_o, wr_state != WR_IDLE, dev_cnt});
	wire [31:0] rd_mux = av_address_i == `OFS_AUX_CTRL ? aux_ctrl :
		av_address_i == `OFS_PF_CTRL ? pf_ctrl :
		av_address_i == `OFS_STATUS ? status : 32'h0000_0000;

	always_ff @(posedge clk_i) begin
		if (!reset_n_i) begin
			av_waitrequest_o <= 1'b1;
			av_readdata_o <= '0;
		end else begin
			av_waitrequest_o <= !(av_req && av_waitrequest_o);
			if (av_req && av_waitrequest_o)
				av_readdata_o <= rd_mux;
		end
	end

	always_ff @(posedge clk_i) begin
		if (!reset_n_i) begin
			aux_ctrl <= `AUX_RESET; // see R2 see R8
			pf_ctrl <= `PF_RESET;
		end else if (av_wr && av_address_i == `OFS_AUX_CTRL) begin
			aux_ctrl <= merge(aux_ctrl, av_writedata_i, be_bits & `AUX_WMASK);
		end else if (av_wr && av_address_i == `OFS_PF_CTRL) begin
			pf_ctrl <= merge(pf_ctrl, av_writedata_i, be_bits & `PF_WMASK);
		end
	end

	// write path
	wire early_en = aux_ctrl[`AUX_EARLY_BIT];
	wire flz_en = aux_ctrl[`AUX_FLZ_BIT];
	wire lim_en = aux_ctrl[`AUX_DEVLIM_BIT];
	wire aw_take = aw_valid_i && aw_ready_o;
	wire sb_take = sb_valid_o && sb_ready_i;
	wire b_take = b_valid_o && b_ready_i;
	wire aw_zero = flz_en && write_addr_user_sideband[`AW_ZERO_BIT]; // see R6 see R8
	wire data_done = w_data_done || w_last_done_i;
	wire next_dev = aw_take ? aw_device_i : sb_device_o;
	wire [CNTW-1:0] next_dev_cnt = dev_cnt + CNTW'(sb_take && sb_device_o) - CNTW'(sb_dev_drained_i);
	// with aux bit 11 set, one slot of three left for normal writes
	wire dev_full = lim_en && next_dev && next_dev_cnt >= CNTW'(`SB_SLOTS - 1); // see R16 see R21

	always_comb begin
		next_wr_state = wr_state;
		case (wr_state)
			WR_IDLE: if (aw_take) next_wr_state = WR_STORE;
			WR_STORE: if (sb_take) next_wr_state = w_early ? WR_RESP : WR_DATA; // see R1
			WR_DATA: if (data_done) next_wr_state = w_sent ? WR_IDLE : WR_RESP;
			WR_RESP: if (b_take) next_wr_state = data_done ? WR_IDLE : WR_DATA;
			default: next_wr_state = WR_IDLE;
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (!reset_n_i) begin
			wr_state <= WR_IDLE;
			aw_ready_o <= 1'b0;
			sb_valid_o <= 1'b0;
			b_valid_o <= 1'b0;
			dev_cnt <= '0;
			w_data_done <= 1'b0;
			w_sent <= 1'b0;
		end else begin
			wr_state <= next_wr_state;
			aw_ready_o <= next_wr_state == WR_IDLE;
			sb_valid_o <= next_wr_state == WR_STORE && !dev_full; // see R16
			b_valid_o <= next_wr_state == WR_RESP;
			dev_cnt <= next_dev_cnt;
			w_data_done <= next_wr_state != WR_IDLE && (w_data_done || (wr_state != WR_IDLE && w_last_done_i));
			w_sent <= next_wr_state != WR_IDLE && (w_sent || b_take);
		end
	end

	// sideband bits ride with the address until the write completes
	always_ff @(posedge clk_i) begin
		if (!reset_n_i) begin
			w_early <= 1'b0;
			b_id_o <= '0;
			sb_addr_o <= '0;
			sb_len_o <= '0;
			sb_zero_line_o <= 1'b0;
			sb_device_o <= 1'b0;
		end else if (aw_take) begin // see R23
			w_early <= early_en && write_addr_user_sideband[`AW_EARLY_BIT]; // see R2 see R3
			b_id_o <= aw_id_i;
			sb_addr_o <= aw_zero ? {aw_addr_i[AW-1:LSB], {LSB{1'b0}}} : aw_addr_i; // see R7 see R22
			sb_len_o <= aw_zero ? '0 : aw_len_i; // see R7
			sb_zero_line_o <= aw_zero; // see R6
			sb_device_o <= aw_device_i;
		end
	end

	// read path
	wire ar_take = ar_valid_i && ar_ready_o;
	wire ar_hint = read_addr_user_sideband[`AR_HINT_BIT]; // see R4 see R5
	wire ar_spec = SPEC_READ_OPTION && read_addr_user_sideband[`AR_SPEC_BIT] && !ar_hint; // see R11
	wire ar_conf = !ar_hint && !ar_spec && spec_link.hit; // see R12
	wire pf_en = aux_ctrl[`AUX_PF_D_BIT] || aux_ctrl[`AUX_PF_I_BIT] ||
		pf_ctrl[`AUX_PF_D_BIT] || pf_ctrl[`AUX_PF_I_BIT];
	wire lk_busy_next = ar_take || (lk_valid_o && !lk_ready_i);
	lookup_kind_t next_kind;
	assign next_kind = ar_hint ? LK_HINT : ar_spec ? LK_SPEC : ar_conf ? LK_CONFIRM : LK_NORMAL;

	assign spec_link.open_req = ar_take && ar_spec;
	assign spec_link.conf_req = ar_take && !ar_hint && !ar_spec;
	assign spec_link.addr = ar_addr_i;
	assign spec_link.id = ar_id_i;
	assign pf_link.trig = ar_take && ar_cacheable_i && pf_en && !ar_hint && !ar_spec; // see R17
	assign pf_link.trig_addr = ar_addr_i;
	assign pf_link.offset = pf_ctrl[`PF_OFS_MSB:0]; // see R18

	always_ff @(posedge clk_i) begin
		if (!reset_n_i) begin
			lk_valid_o <= 1'b0;
			ar_ready_o <= 1'b0;
			lk_addr_o <= '0;
			lk_id_o <= '0;
			lk_kind_o <= LK_NORMAL;
		end else begin
			lk_valid_o <= lk_busy_next;
			// refusing all reads while speculation is full keeps ready a flop
			ar_ready_o <= !lk_busy_next && !spec_link.full;
			if (ar_take) begin // see R23
				lk_addr_o <= ar_addr_i;
				lk_id_o <= ar_id_i;
				lk_kind_o <= next_kind; // see R4 see R11
			end
		end
	end

	if (SPEC_READ_OPTION) begin : g_spec // see R15
		spec_read_tracker #(.DEPTH(SPEC_DEPTH), .TIMEOUT(SPEC_TIMEOUT), .IW(IW), .AW(AW)) u_spec (
			.clk_i(clk_i),
			.reset_n_i(reset_n_i),
			.conflict_i(spec_conflict_i),
			.link(spec_link.trk),
			.end_strobe_o(spec_read_end_strobe),
			.end_id_o(spec_read_end_id)
		);
	end else begin : g_nospec
		assign spec_link.hit = 1'b0;
		assign spec_link.full = 1'b0;
		always_ff @(posedge clk_i) begin
			spec_read_end_strobe <= 1'b0;
			spec_read_end_id <= '0;
		end
	end

	prefetch_engine #(.AW(AW)) u_pf (
		.clk_i(clk_i),
		.reset_n_i(reset_n_i),
		.link(pf_link.eng),
		.lk_valid_o(pf_lk_valid_o),
		.lk_ready_i(pf_lk_ready_i),
		.addr_o(pf_addr_o),
		.res_valid_i(pf_res_valid_i),
		.res_miss_i(pf_res_miss_i),
		.l3_valid_o(pf_l3_valid_o),
		.l3_ready_i(pf_l3_ready_i)
	);

	default clocking @(posedge clk_i); endclocking
	default disable iff (!reset_n_i);
	sequence s_early_accept;
		sb_valid_o && sb_ready_i && w_early;
	endsequence
	a_early_resp_next: assert property (s_early_accept |=> b_valid_o) // see R1
		else $error("early response not sent after address accept");
	a_early_only_tag: assert property (b_valid_o && !w_data_done |-> w_early) // see R3
		else $error("response before last data without early tag");
	a_ctrl_reset_off: assert property ($rose(reset_n_i) |-> aux_ctrl == `AUX_RESET) // see R2
		else $error("options not off after reset");
	a_zero_capture: assert property (aw_take && aw_zero |=> sb_zero_line_o) // see R6
		else $error("zero line write not flagged");
	a_zero_ignore: assert property (sb_valid_o && sb_zero_line_o |-> sb_addr_o[LSB-1:0] == '0 && sb_len_o == '0) // see R7
		else $error("zero line write kept size or offset");
	a_hint_kind: assert property (ar_take && ar_hint |=> lk_valid_o && lk_kind_o == LK_HINT) // see R4
		else $error("prefetch hint not marked");
	a_dev_cap: assert property (sb_valid_o && sb_device_o && lim_en |-> dev_cnt < CNTW'(`SB_SLOTS - 1)) // see R16
		else $error("device writes fill the store buffer");
	a_side_held: assert property (sb_valid_o && !sb_ready_i |=> $stable(sb_addr_o) && $stable(sb_zero_line_o)) // see R23
		else $error("sideband changed before handshake");
endmodule

// *** tb/mem_side_model.sv ***
// Purpose: memory-side responder: store buffer, lookup pipe and L3 fetch
// Assumes: one clock; slow mode answers only on every other cycle
// Notes: last data beat follows the address by three cycles
`timescale 1ns/1ps
module mem_side_model (
	input wire logic clk_i, // core clock
	input wire logic slow_i, // hold ready off on odd cycles
	input wire logic miss_i, // prefetch lookups miss
	input wire logic sb_valid_i, // store buffer request
	output logic sb_ready_o, // store buffer took address
	output logic w_last_done_o, // last data beat taken
	input wire logic lk_valid_i, // lookup request
	output logic lk_ready_o, // lookup taken
	input wire logic pf_lk_valid_i, // prefetch lookup request
	output logic pf_lk_ready_o, // prefetch lookup taken
	output logic pf_res_valid_o, // prefetch result pulse
	output logic pf_res_miss_o, // result missed
	input wire logic pf_l3_valid_i, // fetch request
	output logic pf_l3_ready_o // fetch taken
);
	logic tick = 1'b0;
	logic res = 1'b0;
	logic [2:0] lag = 3'h0;
	wire go = tick | ~slow_i;
	assign sb_ready_o = sb_valid_i & go;
	assign lk_ready_o = lk_valid_i & go;
	assign pf_lk_ready_o = pf_lk_valid_i & go;
	assign pf_l3_ready_o = pf_l3_valid_i & go;
	assign w_last_done_o = lag[2];
	assign pf_res_valid_o = res;
	// qualifier toggles when no result stands, so a stale level never reads as valid
	assign pf_res_miss_o = res ? miss_i : tick;
	always @(posedge clk_i) begin
		tick <= ~tick;
		lag <= {lag[1:0], sb_valid_i & sb_ready_o};
		res <= pf_lk_valid_i & pf_lk_ready_o;
	end
endmodule

// *** tb/tb.sv ***
// Purpose: register, write, read, speculation and prefetch tests
// Assumes: short speculative timeout for run length
// Notes: outputs are read at the edge, before that edge's updates land
`timescale 1ns/1ps
module tb import cache_opt_pkg::*;;
	logic clk_i, reset_n_i, av_read_i, av_write_i, av_waitrequest_o, aw_valid_i, aw_ready_o, w_last_done_i;
	logic b_valid_o, sb_valid_o, sb_ready_i, sb_zero_line_o, sb_device_o, ar_valid_i, ar_ready_o, ar_cacheable_i;
	logic lk_valid_o, lk_ready_i, pf_lk_valid_o, pf_lk_ready_i, pf_res_valid_i, pf_res_miss_i, pf_l3_valid_o;
	logic pf_l3_ready_i, spec_read_end_strobe, slow, miss, last_seen;
	logic b_ready_i = 1'b1;
	logic aw_device_i = 1'b0;
	logic sb_dev_drained_i = 1'b0;
	logic spec_conflict_i = 1'b0;
	logic [3:0] av_byteenable_i = 4'hf;
	logic [31:0] av_writedata_i, av_readdata_o, aw_addr_i, sb_addr_o, ar_addr_i, lk_addr_o, pf_addr_o, pf_seen;
	logic [11:0] write_addr_user_sideband, read_addr_user_sideband;
	logic [7:0] aw_len_i, sb_len_o;
	logic [3:0] av_address_i, aw_id_i, b_id_o, ar_id_i, lk_id_o, spec_read_end_id, end_id;
	lookup_kind_t lk_kind_o;
	int err_count = 0, num_checks = 0, ends = 0, pfs = 0, l3s = 0;
	cache_sideband_opt_prefetch #(.SPEC_TIMEOUT(24)) u_cache_sideband_opt_prefetch (.clk_i, .reset_n_i,
		.av_address_i, .av_read_i, .av_write_i, .av_byteenable_i, .av_writedata_i, .av_readdata_o, .av_waitrequest_o,
		.aw_valid_i, .aw_ready_o, .aw_addr_i, .aw_id_i, .aw_len_i, .aw_device_i, .write_addr_user_sideband,
		.w_last_done_i, .b_valid_o, .b_ready_i, .b_id_o, .sb_valid_o, .sb_ready_i, .sb_addr_o, .sb_len_o,
		.sb_zero_line_o, .sb_device_o, .sb_dev_drained_i, .ar_valid_i, .ar_ready_o, .ar_addr_i, .ar_id_i,
		.ar_cacheable_i, .read_addr_user_sideband, .lk_valid_o, .lk_ready_i, .lk_addr_o, .lk_id_o, .lk_kind_o,
		.pf_lk_valid_o, .pf_lk_ready_i, .pf_addr_o, .pf_res_valid_i, .pf_res_miss_i, .pf_l3_valid_o,
		.pf_l3_ready_i, .spec_conflict_i, .spec_read_end_strobe, .spec_read_end_id);
	mem_side_model u_mem_side_model (.clk_i, .slow_i(slow), .miss_i(miss), .sb_valid_i(sb_valid_o),
		.sb_ready_o(sb_ready_i), .w_last_done_o(w_last_done_i), .lk_valid_i(lk_valid_o), .lk_ready_o(lk_ready_i),
		.pf_lk_valid_i(pf_lk_valid_o), .pf_lk_ready_o(pf_lk_ready_i), .pf_res_valid_o(pf_res_valid_i),
		.pf_res_miss_o(pf_res_miss_i), .pf_l3_valid_i(pf_l3_valid_o), .pf_l3_ready_o(pf_l3_ready_i));
	initial begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end
	always @(posedge clk_i) begin
		if (w_last_done_i) last_seen <= 1'b1;
		if (spec_read_end_strobe) begin
			ends <= ends + 1;
			end_id <= spec_read_end_id;
		end
		if (pf_lk_valid_o && pf_lk_ready_i) begin
			pfs <= pfs + 1;
			pf_seen <= pf_addr_o;
		end
		if (pf_l3_valid_o && pf_l3_ready_i) l3s <= l3s + 1;
	end
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		num_checks++;
		if (got !== exp) begin
			err_count++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic av(input logic wr, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q);
		int n;
		n = 0;
		av_address_i <= a;
		av_writedata_i <= d;
		av_write_i <= wr;
		av_read_i <= ~wr;
		do @(posedge clk_i); while (av_waitrequest_o !== 1'b0 && ++n < 50);
		if (n >= 50) err_count++;
		q = av_readdata_o;
		av_write_i <= 1'b0;
		av_read_i <= 1'b0;
		@(posedge clk_i);
	endtask
	task automatic axw(input logic [31:0] a, input logic [11:0] u, input logic early, input logic z);
		int n;
		n = 0;
		aw_addr_i <= a;
		write_addr_user_sideband <= u;
		aw_id_i <= 4'h3;
		aw_len_i <= 8'h07;
		aw_valid_i <= 1'b1;
		do @(posedge clk_i); while (aw_ready_o !== 1'b1 && ++n < 50);
		aw_valid_i <= 1'b0;
		last_seen <= 1'b0;
		do @(posedge clk_i); while (!(sb_valid_o === 1'b1 && sb_ready_i) && ++n < 50);
		chk("sb_zero_line", z, sb_zero_line_o);
		chk("sb_addr", z ? a & 32'hffff_ffe0 : a, sb_addr_o);
		chk("sb_len", z ? 32'h0 : 32'h7, sb_len_o);
		do @(posedge clk_i); while (b_valid_o !== 1'b1 && ++n < 50);
		chk("last beat before response", !early, last_seen);
		chk("b_id", 32'h3, b_id_o);
		while (aw_ready_o !== 1'b1 && ++n < 50) @(posedge clk_i);
		if (n >= 50) err_count++;
	endtask
	task automatic axr(input logic [31:0] a, input logic [3:0] id, input logic [11:0] u, input logic c,
		input lookup_kind_t k);
		int n;
		n = 0;
		ar_addr_i <= a;
		ar_id_i <= id;
		read_addr_user_sideband <= u;
		ar_cacheable_i <= c;
		ar_valid_i <= 1'b1;
		do @(posedge clk_i); while (ar_ready_o !== 1'b1 && ++n < 50);
		ar_valid_i <= 1'b0;
		do @(posedge clk_i); while (!(lk_valid_o === 1'b1 && lk_ready_i) && ++n < 50);
		if (n >= 50) err_count++;
		chk("lk_kind", k, lk_kind_o);
		chk("lk_addr", a, lk_addr_o);
		chk("lk_id", id, lk_id_o);
		repeat (8) @(posedge clk_i);
	endtask
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	initial begin
		repeat (5000) @(posedge clk_i);
		err_count++;
		report_and_stop();
	end
	initial begin
		logic [31:0] q;
		int e0;
		{reset_n_i, av_read_i, av_write_i, aw_valid_i, ar_valid_i, slow, ar_cacheable_i, last_seen} = '0;
		{av_address_i, av_writedata_i, aw_addr_i, aw_id_i, aw_len_i, ar_addr_i, ar_id_i} = '0;
		{write_addr_user_sideband, read_addr_user_sideband} = '0;
		miss = 1'b1;
		repeat (10) @(posedge clk_i);
		reset_n_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		av(0, 4'h0, 0, q);
		chk("aux reset", 0, q);
		av(0, 4'h4, 0, q);
		chk("prefetch ctrl reset", 0, q);
		av(0, 4'h8, 0, q);
		chk("status idle", 0, q);
		av(1, 4'h0, 32'hffff_ffff, q);
		av(0, 4'h0, 0, q);
		chk("aux bits", 32'h7000_0801, q);
		av(1, 4'h4, 32'hffff_ffff, q);
		av(0, 4'h4, 0, q);
		chk("prefetch ctrl bits", 32'h3000_001f, q);
		av(0, 4'hc, 0, q);
		chk("unmapped", 0, q);
		av(1, 4'h4, 0, q);
		$display("registers done");
		av(1, 4'h0, 0, q);
		axw(32'h40, 12'h800, 0, 0);
		av(1, 4'h0, 32'h4000_0001, q);
		axw(32'h80, 12'h800, 1, 0);
		axw(32'hc0, 12'h000, 0, 0);
		axw(32'h1234, 12'h400, 0, 1);
		slow <= 1'b1;
		av(1, 4'h0, 32'h4000_0000, q);
		axw(32'h1234, 12'h400, 0, 0);
		$display("writes done");
		av(1, 4'h0, 0, q);
		e0 = ends;
		axr(32'h100, 4'h1, 12'h100, 1, LK_HINT);
		axr(32'h400, 4'h5, 12'h200, 0, LK_SPEC);
		axr(32'h400, 4'h5, 12'h000, 0, LK_CONFIRM);
		chk("ends after confirm", e0 + 1, ends);
		chk("end id", 32'h5, end_id);
		axr(32'h800, 4'h9, 12'h200, 0, LK_SPEC);
		repeat (40) @(posedge clk_i);
		chk("ends after timeout", e0 + 2, ends);
		chk("end id", 32'h9, end_id);
		axr(32'ha00, 4'h6, 12'h200, 0, LK_SPEC);
		spec_conflict_i <= 1'b1;
		@(posedge clk_i);
		spec_conflict_i <= 1'b0;
		repeat (2) @(posedge clk_i);
		chk("ends after conflict", e0 + 3, ends);
		chk("conflict end id", 32'h6, end_id);
		chk("prefetch while off", 0, pfs);
		$display("reads done");
		av(1, 4'h0, 32'h1000_0000, q);
		axr(32'h100, 4'h2, 12'h000, 1, LK_NORMAL);
		chk("prefetch count", 1, pfs);
		chk("prefetch addr", 32'h120, pf_seen);
		chk("l3 fetch", 1, l3s);
		miss <= 1'b0;
		av(1, 4'h4, 32'h3, q);
		axr(32'h100, 4'h2, 12'h000, 1, LK_NORMAL);
		chk("prefetch addr offset", 32'h180, pf_seen);
		chk("no fetch on hit", 1, l3s);
		axr(32'hfe0, 4'h2, 12'h000, 1, LK_NORMAL);
		chk("page crossing", 2, pfs);
		$display("prefetch done");
		report_and_stop();
	end
endmodule
